/* File: dv/host_master.sv */
// two wire bus master model that paces the bus from the system clock
`timescale 1ns/10ps

module host_master
(
    // pacing clock and resolved data wire
    input wire logic clk,
    input wire logic sda_wire,
    // driven lines, high means released to the pull-up
    output logic scl,
    output logic sda
);
    // idle bus rests high
    initial
    begin
        scl = 1'h1; // master owns the clock
        sda = 1'h1;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    // also serves as repeated start from mid frame
    task automatic start();
        sda <= 1'h1;
        tick(4);
        scl <= 1'h1;
        tick(4);
        sda <= 1'h0;
        tick(4);
        scl <= 1'h0;
    endtask

    task automatic stop();
        sda <= 1'h0;
        tick(4);
        scl <= 1'h1;
        tick(4);
        sda <= 1'h1;
        tick(4);
    endtask

    // data moves only in the low half, sampled at end of high
    task automatic bit_cycle(input logic b, output logic seen);
        tick(2);
        sda <= b;
        tick(2);
        scl <= 1'h1;
        tick(4);
        seen = sda_wire;
        scl <= 1'h0;
    endtask

    // eight bits then the ninth clock driving ack_out; a one releases for the peer's ack
    task automatic xfer(input logic [7:0] tx, input logic ack_out,
                        output logic [7:0] rx, output logic ack_in);
        for (int i = 7; i >= 0; i--)
            bit_cycle(tx[i], rx[i]);
        bit_cycle(ack_out, ack_in);
    endtask
endmodule

/* File: dv/thermal_sensor_serial_slave_tb.sv */
// self-checking bench for the temperature monitor serial slave
`timescale 1ns/10ps

module thermal_sensor_serial_slave_tb;
    import thermal_sensor_pkg::*;
    logic clk;
    logic rst_n;
    logic [2:0] strap;
    logic sample_valid;
    logic [8:0] sample_data;
    logic sample_ready;
    logic sda_o;
    logic sda_oe;
    logic alert;
    logic scl;
    logic host_sda;
    logic [7:0] rx;
    logic [15:0] got;
    int miscompares;
    int checks;
    // pull-up level unless someone pulls low
    wire logic sda_wire = sda_oe ? sda_o : host_sda;
    wire logic [6:0] dev = {ADDR_FIXED, strap};

    thermal_sensor_serial_slave DUT
    (
        .CLK_SYS(clk), .RST_N(rst_n), .SCL(scl), .SDA_I(sda_wire),
        .SDA_O(sda_o), .SDA_OE(sda_oe), .STRAP_ADDR_BIT2(strap[2]),
        .STRAP_ADDR_BIT1(strap[1]), .STRAP_ADDR_BIT0(strap[0]),
        .SAMPLE_VALID(sample_valid), .SAMPLE_DATA(sample_data),
        .SAMPLE_READY(sample_ready), .ALERT_OUTPUT(alert)
    );
    host_master host (.clk(clk), .sda_wire(sda_wire), .scl(scl),
                      .sda(host_sda));

    initial
    begin
        clk = 1'h0;
        forever #10 clk = ~clk;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic chk(input string n, input logic [15:0] e,
                       input logic [15:0] g);
        checks++;
        if (g !== e)
        begin
            miscompares++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask

    task automatic results();
        if (miscompares == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // selector byte then n data bytes, high byte first
    task automatic wr(input logic [1:0] s, input int n, input logic [15:0] d);
        logic a;
        host.start();
        host.xfer({dev, 1'h0}, 1'h1, rx, a);
        chk("addr ack", 16'h0000, {15'h0, a});
        host.xfer({6'h00, s}, 1'h1, rx, a);
        chk("sel ack", 16'h0000, {15'h0, a});
        for (int i = 0; i < n; i++)
        begin
            host.xfer(i == 0 ? d[15:8] : d[7:0], 1'h1, rx, a);
            chk("data ack", 16'h0000, {15'h0, a});
        end
        host.stop();
    endtask

    task automatic rd(input logic [15:0] e, input string n);
        logic a;
        host.start();
        host.xfer({dev, 1'h1}, 1'h1, rx, a);
        chk("read ack", 16'h0000, {15'h0, a});
        host.xfer(8'hFF, 1'h0, got[15:8], a);
        host.xfer(8'hFF, 1'h1, got[7:0], a);
        host.stop();
        chk(n, e, got);
    endtask

    // hold the word until ready is seen at an edge
    task automatic push(input logic [8:0] d);
        logic r;
        sample_valid <= 1'h1;
        sample_data <= d;
        repeat (50)
        begin
            @(negedge clk);
            r = sample_ready;
            @(posedge clk);
            if (r === 1'h1)
                break;
        end
        sample_valid <= 1'h0;
        chk("sample ready", 16'h0001, {15'h0, r});
        tick(4);
    endtask

    task automatic t_reset();
        chk("oe", 16'h0000, {15'h0, sda_oe});
        chk("ready", 16'h0001, {15'h0, sample_ready});
        chk("alert", 16'h0001, {15'h0, alert});
        rd(16'h0000, "ambient rst");
        wr(SEL_TRIP, 0, 16'h0000);
        rd(16'h3200, "trip rst");
        wr(SEL_RELEASE, 0, 16'h0000);
        rd(16'h2D00, "release rst");
        wr(SEL_CONFIG, 0, 16'h0000);
        rd(16'h0000, "config rst");
    endtask

    // foreign strap bits or foreign fixed nibble get no ack
    task automatic t_addr();
        logic a;
        for (int k = 0; k < 8; k++)
        begin
            strap <= k[2:0];
            tick(4);
            host.start();
            host.xfer(k[0] ? {~ADDR_FIXED, k[2:0], 1'h0}
                           : {ADDR_FIXED, ~k[2:0], 1'h0}, 1'h1, rx, a);
            host.stop();
            chk("foreign ack", 16'h0001, {15'h0, a});
            host.start();
            host.xfer({dev, 1'h0}, 1'h1, rx, a);
            host.stop();
            chk("own ack", 16'h0000, {15'h0, a});
        end
    endtask

    task automatic t_regs();
        wr(SEL_TRIP, 2, 16'h3C80);
        wr(SEL_RELEASE, 2, 16'h1E00);
        wr(SEL_AMBIENT, 2, 16'hFFFF);
        rd(16'h0000, "ambient ro");
        wr(SEL_TRIP, 0, 16'h0000);
        rd(16'h3C80, "trip");
        rd(16'h3C80, "trip held");
        wr(SEL_RELEASE, 0, 16'h0000);
        rd(16'h1E00, "release");
    endtask

    // trip is 121 counts, release 60; below sample is negative
    task automatic t_queue();
        int depth [4] = '{1, 2, 4, 6};
        for (int q = 0; q < 4; q++)
        begin
            wr(SEL_CONFIG, 1, {3'h0, q[1:0], 11'h000});
            repeat (depth[q] - 1) push(9'h07A);
            chk("alert early", 16'h0001, {15'h0, alert});
            push(9'h07A);
            chk("alert set", 16'h0000, {15'h0, alert});
            repeat (depth[q] - 1) push(9'h1CE);
            chk("alert held", 16'h0000, {15'h0, alert});
            push(9'h1CE);
            chk("alert clear", 16'h0001, {15'h0, alert});
        end
        wr(SEL_AMBIENT, 0, 16'h0000);
        rd(16'hE700, "ambient");
    endtask

    task automatic t_intr();
        wr(SEL_CONFIG, 1, 16'h0600);
        chk("idle high pol", 16'h0000, {15'h0, alert});
        push(9'h07A);
        chk("int set", 16'h0001, {15'h0, alert});
        rd(16'h0606, "config");
        chk("int read clr", 16'h0000, {15'h0, alert});
        push(9'h1CE);
        chk("int below", 16'h0001, {15'h0, alert});
        wr(SEL_CONFIG, 1, 16'h0700);
        chk("shut clr", 16'h0000, {15'h0, alert});
    endtask

    // nothing drains in shutdown, bus still answers
    task automatic t_shut();
        repeat (16) push(9'h001);
        chk("fifo full", 16'h0000, {15'h0, sample_ready});
        wr(SEL_AMBIENT, 0, 16'h0000);
        rd(16'hE700, "halted");
        wr(SEL_CONFIG, 1, 16'h0000);
        tick(20);
        chk("fifo empty", 16'h0001, {15'h0, sample_ready});
        wr(SEL_AMBIENT, 0, 16'h0000);
        rd(16'h0080, "drained");
    endtask

    initial
    begin
        rst_n = 1'h0;
        strap = 3'h0;
        sample_valid = 1'h0;
        sample_data = 9'h000;
        miscompares = 0;
        checks = 0;
        tick(8);
        rst_n <= 1'h1;
        tick(4);
        t_reset();
        t_addr();
        t_regs();
        t_queue();
        t_intr();
        t_shut();
        results();
    end

    // hang guard well past the expected run length
    initial
    begin
        repeat (90000) @(posedge clk);
        $display("BAD watchdog exp done got timeout");
        miscompares++;
        results();
    end
endmodule

/* File: dv/thermal_sensor_sva.sv */
// concurrent checks on the serial slave ports
`timescale 1ns/10ps

module thermal_sensor_sva
(
    // clock and reset
    input wire logic CLK_SYS,
    input wire logic RST_N,
    // bus lines
    input wire logic SCL,
    input wire logic SDA_I,
    input wire logic SDA_O,
    input wire logic SDA_OE,
    // conversion stream and alert
    input wire logic SAMPLE_VALID,
    input wire logic SAMPLE_READY,
    input wire logic ALERT_OUTPUT
);
    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (!RST_N);

    // clock high long enough to have passed the synchroniser
    sequence scl_held_high;
        SCL && $past(SCL) && $past(SCL, 2) && $past(SCL, 3);
    endsequence
    // data rising while clock high
    sequence stop_seen;
        SCL && $rose(SDA_I);
    endsequence

    // open drain: only ever pulls low
    sda_low_only_a: assert property (SDA_O == 1'h0)
        else $error("data output not low");
    data_steady_a: assert property (
        scl_held_high |-> $stable(SDA_OE))
        else $error("data drive changed with clock high");
    stop_release_a: assert property (stop_seen |=> !SDA_OE [*8])
        else $error("data driven after stop");
    ack_hold_a: assert property ($rose(SDA_OE) |-> SDA_OE [*5])
        else $error("low drive too short");
    drive_on_low_a: assert property (
        $rose(SDA_OE) |-> !SCL && !$past(SCL))
        else $error("drive began with clock high");
    release_on_low_a: assert property ($fell(SDA_OE) |-> !SCL)
        else $error("release with clock high");
    ready_cause_a: assert property (
        $fell(SAMPLE_READY) |-> $past(SAMPLE_VALID))
        else $error("ready dropped without a word");
    reset_exit_a: assert property (
        $rose(RST_N) |-> !SDA_OE && SAMPLE_READY && ALERT_OUTPUT)
        else $error("outputs wrong after reset");
endmodule

bind thermal_sensor_serial_slave thermal_sensor_sva u_sva
(
    .CLK_SYS(CLK_SYS), .RST_N(RST_N), .SCL(SCL), .SDA_I(SDA_I),
    .SDA_O(SDA_O), .SDA_OE(SDA_OE), .SAMPLE_VALID(SAMPLE_VALID),
    .SAMPLE_READY(SAMPLE_READY), .ALERT_OUTPUT(ALERT_OUTPUT)
);

/* File: verilog/thermal_sensor_pkg.sv */
// shared constants and types for the temperature monitor serial slave
package thermal_sensor_pkg;

    // fixed upper nibble of the seven bit slave address
    localparam logic [3:0] ADDR_FIXED = 4'h9;

    // selector codes in bits 1:0 of the register selector
    localparam logic [1:0] SEL_AMBIENT = 2'h0;
    localparam logic [1:0] SEL_CONFIG = 2'h1;
    localparam logic [1:0] SEL_RELEASE = 2'h2;
    localparam logic [1:0] SEL_TRIP = 2'h3;

    // field positions inside the configuration byte
    localparam int CFG_SHUTDOWN_POS = 0;
    localparam int CFG_MODE_POS = 1;
    localparam int CFG_POL_POS = 2;
    localparam int CFG_QUEUE_LSB = 3;

    // values after reset
    localparam logic [7:0] CONFIG_RESET = 8'h00;
    localparam logic [1:0] SELECTOR_RESET = 2'h0;
    localparam logic [15:0] AMBIENT_RESET = 16'h0000;
    localparam logic [15:0] TRIP_RESET = 16'h3200;
    localparam logic [15:0] RELEASE_RESET = 16'h2D00;

    // reading layout: nine bit value sits in bits 15:7
    localparam int READING_W = 9;
    localparam int READING_LSB = 7;

    // fault queue depths for codes 0..3, and conversion buffer shape
    localparam logic [2:0] QUEUE_DEPTH_0 = 3'h1;
    localparam logic [2:0] QUEUE_DEPTH_1 = 3'h2;
    localparam logic [2:0] QUEUE_DEPTH_2 = 3'h4;
    localparam logic [2:0] QUEUE_DEPTH_3 = 3'h6;
    localparam int SAMPLE_FIFO_DEPTH = 16;

    // sampled bus lines
    typedef struct packed {
        logic scl;
        logic sda;
    } bus_lines_t;

    // configuration byte layout
    typedef struct packed {
        logic [2:0] zero;
        logic [1:0] queue;
        logic polarity;
        logic mode;
        logic shutdown;
    } config_t;

    // serial engine states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_RECV,
        ST_ACK,
        ST_SEND,
        ST_HOST_ACK
    } link_state_t;

endpackage

/* File: verilog/thermal_sensor_serial_slave.sv */
// serial slave, register set, alert logic and conversion buffer
// Summary of operation
// [R01] start is data falling while clock high
// [R02] stop is data rising while clock high
// [R03] receiver pulls data low on ninth clock
// [R04] idle bus: device releases both lines
// [R05] data changes only while clock low
// [R06] device is slave, never drives clock
// [R07] all bytes shifted most significant first
// [R08] host frames: start, address, data, stop
// [R09] ignore bus until a start is seen
// [R10] acknowledge only fixed nibble plus straps
// [R11] address bit zero: one read, zero write
// [R12] device pulls data low on ninth clock
// [R13] acknowledge every data byte written
// [R14] selector low bits choose target register
// [R15] config bit 0 selects shutdown
// [R16] config bit 1 selects interrupt mode
// [R17] config bit 2 selects alert polarity
// [R18] config bits 4:3 set fault queue
// [R19] reading is nine bits in 15:7
// [R20] trip and release thresholds read write
// [R21] two's complement, half degree per count
// [R22] reading updates after each conversion
// [R23] comparator: set above trip, clear below release
// [R24] interrupt mode: any read clears alert
// [R25] shutdown halts conversions, bus still works
// [R26] interrupt mode: shutdown entry clears alert
// [R27] first write byte selects, rest write register
// [R28] selector holds its value between accesses
`timescale 1ns/10ps

module sample_fifo
    import thermal_sensor_pkg::*;
#(
    parameter int WIDTH = 9,
    parameter int DEPTH = 16
)
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // filling side
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    // draining side
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
    logic [AW:0] cnt_q, cnt_d;
    logic full_q, full_d;
    logic push, pop;

    // full is registered so the ready seen upstream is a flop
    always_comb
    begin
        push = in_valid && !full_q;
        pop = out_valid && out_ready;
        wr_d = push ? wr_q + 1'b1 : wr_q;
        rd_d = pop ? rd_q + 1'b1 : rd_q;
        cnt_d = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        full_d = (cnt_d == (AW+1)'(DEPTH));
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
            full_q <= 1'b0;
        end
        else
        begin
            wr_q <= wr_d;
            rd_q <= rd_d;
            cnt_q <= cnt_d;
            full_q <= full_d;
        end
    end

    // storage has no reset; only written words are ever read
    always_ff @(posedge clk)
    begin
        if (push)
            mem[wr_q] <= in_data;
    end

    assign in_ready = !full_q;
    assign out_valid = (cnt_q != '0);
    assign out_data = mem[rd_q];
endmodule

`timescale 1ns/10ps

module thermal_sensor_serial_slave
    import thermal_sensor_pkg::*;
(
    // system clock and reset
    input wire logic CLK_SYS,
    input wire logic RST_N,
    // two wire bus, clock is input only
    input wire logic SCL,
    input wire logic SDA_I,
    output logic SDA_O,
    output logic SDA_OE,
    // address straps
    input wire logic STRAP_ADDR_BIT2,
    input wire logic STRAP_ADDR_BIT1,
    input wire logic STRAP_ADDR_BIT0,
    // conversion results from the converter
    input wire logic SAMPLE_VALID,
    input wire logic [READING_W-1:0] SAMPLE_DATA,
    output logic SAMPLE_READY,
    // alert pin level
    output logic ALERT_OUTPUT
);
    // fault queue code to number of agreeing conversions
    function automatic logic [2:0] queue_need(input logic [1:0] code);
        unique case (code)
            2'h0: queue_need = QUEUE_DEPTH_0;
            2'h1: queue_need = QUEUE_DEPTH_1;
            2'h2: queue_need = QUEUE_DEPTH_2;
            2'h3: queue_need = QUEUE_DEPTH_3;
        endcase
    endfunction

    // synchronisers: stage one feeds stage two only
    bus_lines_t s1_q, s2_q, s3_q;
    logic [2:0] strap_s1_q, strap_s2_q;
    logic scl_rise, scl_fall, start_seen, stop_seen;

    always_ff @(posedge CLK_SYS)
    begin
        if (!RST_N)
        begin
            s1_q <= '1;
            s2_q <= '1;
            s3_q <= '1;
            strap_s1_q <= '0;
            strap_s2_q <= '0;
        end
        else
        begin
            s1_q <= '{scl: SCL, sda: SDA_I};
            s2_q <= s1_q;
            s3_q <= s2_q;
            strap_s1_q <= {STRAP_ADDR_BIT2, STRAP_ADDR_BIT1, STRAP_ADDR_BIT0};
            strap_s2_q <= strap_s1_q;
        end
    end

    // edges on the bus; data moving while clock high is start or stop
    always_comb
    begin
        scl_rise = s2_q.scl && !s3_q.scl;
        scl_fall = !s2_q.scl && s3_q.scl;
        start_seen = s2_q.scl && s3_q.scl && s3_q.sda && !s2_q.sda; // see [R01]
        stop_seen = s2_q.scl && s3_q.scl && !s3_q.sda && s2_q.sda; // see [R02]
    end

    // serial engine and register set
    link_state_t st_q, st_d;
    logic [2:0] cnt_q, cnt_d;
    logic [7:0] sh_q, sh_d;
    logic full_q, full_d;
    logic is_addr_q, is_addr_d;
    logic rd_q, rd_d;
    logic [1:0] widx_q, widx_d;
    logic ridx_q, ridx_d;
    logic oe_q, oe_d;
    logic [1:0] sel_q, sel_d;
    config_t cfg_q, cfg_d;
    logic [15:0] amb_q, amb_d, trip_q, trip_d, rel_q, rel_d;
    logic read_pulse;
    logic [15:0] sel_word;
    logic [7:0] tx_byte;
    logic conv_take;
    logic [READING_W-1:0] conv_data;
    logic conv_valid;

    // selected register for reads; unused low reading bits read zero
    always_comb
    begin
        unique case (sel_q) // see [R14]
            SEL_AMBIENT: sel_word = {amb_q[15:READING_LSB], 7'h00}; // see [R19]
            SEL_CONFIG: sel_word = {cfg_q, cfg_q};
            SEL_RELEASE: sel_word = {rel_q[15:READING_LSB], 7'h00};
            SEL_TRIP: sel_word = {trip_q[15:READING_LSB], 7'h00};
        endcase
        tx_byte = ridx_q ? sel_word[7:0] : sel_word[15:8]; // see [R27]
    end

    always_comb
    begin
        st_d = st_q;
        cnt_d = cnt_q;
        sh_d = sh_q;
        full_d = full_q;
        is_addr_d = is_addr_q;
        rd_d = rd_q;
        widx_d = widx_q;
        ridx_d = ridx_q;
        oe_d = oe_q;
        sel_d = sel_q; // see [R28]
        cfg_d = cfg_q;
        trip_d = trip_q;
        rel_d = rel_q;
        read_pulse = 1'b0;
        // new reading each completed conversion
        amb_d = conv_take ? {conv_data, 7'h00} : amb_q; // see [R22]
        if (stop_seen)
        begin
            st_d = ST_IDLE; // see [R02]
            oe_d = 1'b0; // see [R04]
        end
        else if (start_seen)
        begin
            // also covers a repeated start inside a frame
            st_d = ST_RECV; // see [R09]
            oe_d = 1'b0;
            cnt_d = '0;
            full_d = 1'b0;
            is_addr_d = 1'b1;
            widx_d = '0;
            ridx_d = 1'b0;
        end
        else
        begin
            unique case (st_q)
                ST_IDLE: oe_d = 1'b0; // see [R09]
                ST_RECV:
                begin
                    if (scl_rise)
                    begin
                        sh_d = {sh_q[6:0], s2_q.sda}; // see [R07]
                        cnt_d = cnt_q + 3'h1;
                        full_d = (cnt_q == 3'h7);
                    end
                    else if (scl_fall && full_q)
                    begin
                        // byte done: act on falling edge so ack meets R05
                        full_d = 1'b0;
                        if (is_addr_q)
                        begin
                            if (sh_q[7:1] == {ADDR_FIXED, strap_s2_q}) // see [R10]
                            begin
                                rd_d = sh_q[0]; // see [R11]
                                oe_d = 1'b1; // see [R12]
                                st_d = ST_ACK;
                            end
                            else
                                st_d = ST_IDLE; // see [R09]
                        end
                        else
                        begin
                            unique case (widx_q) // see [R27]
                                2'h0: sel_d = sh_q[1:0]; // see [R14]
                                2'h1:
                                begin
                                    unique case (sel_q)
                                        SEL_CONFIG: cfg_d = sh_q; // see [R15]
                                        SEL_RELEASE: rel_d[15:8] = sh_q; // see [R20]
                                        SEL_TRIP: trip_d[15:8] = sh_q; // see [R20]
                                        SEL_AMBIENT: ; // read only
                                    endcase
                                end
                                default:
                                begin
                                    unique case (sel_q)
                                        SEL_RELEASE: rel_d[7:0] = sh_q;
                                        SEL_TRIP: trip_d[7:0] = sh_q;
                                        default: ;
                                    endcase
                                end
                            endcase
                            if (widx_q != 2'h3)
                                widx_d = widx_q + 2'h1;
                            oe_d = 1'b1; // see [R13]
                            st_d = ST_ACK;
                        end
                    end
                end
                ST_ACK:
                begin
                    // after the ninth clock, on its falling edge: release, or on a read drive the first data bit
                    if (scl_fall)
                    begin
                        cnt_d = '0;
                        if (is_addr_q && rd_q)
                        begin
                            read_pulse = 1'b1; // see [R24]
                            sh_d = tx_byte;
                            oe_d = !tx_byte[7]; // see [R07]
                            ridx_d = 1'b1;
                            st_d = ST_SEND;
                        end
                        else
                        begin
                            oe_d = 1'b0; // see [R03]
                            st_d = ST_RECV;
                        end
                        is_addr_d = 1'b0;
                    end
                end
                ST_SEND:
                begin
                    // shift only while clock low, stable through high
                    if (scl_fall) // see [R05]
                    begin
                        cnt_d = cnt_q + 3'h1;
                        sh_d = {sh_q[6:0], 1'b0};
                        if (cnt_q == 3'h7)
                        begin
                            oe_d = 1'b0;
                            full_d = 1'b0;
                            st_d = ST_HOST_ACK;
                        end
                        else
                            oe_d = !sh_q[6];
                    end
                end
                ST_HOST_ACK:
                begin
                    // host ack keeps the read going, no ack ends it
                    if (scl_rise)
                    begin
                        if (s2_q.sda)
                            st_d = ST_IDLE;
                        else
                            full_d = 1'b1;
                    end
                    else if (scl_fall && full_q)
                    begin
                        full_d = 1'b0;
                        cnt_d = '0;
                        sh_d = tx_byte;
                        oe_d = !tx_byte[7];
                        ridx_d = !ridx_q;
                        st_d = ST_SEND;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge CLK_SYS)
    begin
        if (!RST_N)
        begin
            st_q <= ST_IDLE;
            cnt_q <= '0;
            sh_q <= '0;
            full_q <= 1'b0;
            is_addr_q <= 1'b0;
            rd_q <= 1'b0;
            widx_q <= '0;
            ridx_q <= 1'b0;
            oe_q <= 1'b0;
            sel_q <= SELECTOR_RESET;
            cfg_q <= CONFIG_RESET;
            amb_q <= AMBIENT_RESET;
            trip_q <= TRIP_RESET;
            rel_q <= RELEASE_RESET;
        end
        else
        begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            sh_q <= sh_d;
            full_q <= full_d;
            is_addr_q <= is_addr_d;
            rd_q <= rd_d;
            widx_q <= widx_d;
            ridx_q <= ridx_d;
            oe_q <= oe_d;
            sel_q <= sel_d;
            cfg_q <= cfg_d;
            amb_q <= amb_d;
            trip_q <= trip_d;
            rel_q <= rel_d;
        end
    end

    // open drain data: only ever pulled low, clock never driven
    assign SDA_O = 1'b0; // see [R06]
    assign SDA_OE = oe_q;

    // conversion buffer; shutdown stalls the drain so it fills
    assign conv_take = conv_valid && !cfg_q.shutdown; // see [R25]

    sample_fifo #(
        .WIDTH(READING_W),
        .DEPTH(SAMPLE_FIFO_DEPTH)
    ) u_fifo (
        .clk(CLK_SYS),
        .rst_n(RST_N),
        .in_valid(SAMPLE_VALID),
        .in_data(SAMPLE_DATA),
        .in_ready(SAMPLE_READY),
        .out_valid(conv_valid),
        .out_data(conv_data),
        .out_ready(!cfg_q.shutdown)
    );

    // alert engine: fault queue counters and the alert state
    logic [2:0] hi_cnt_q, hi_cnt_d, lo_cnt_q, lo_cnt_d;
    logic act_q, act_d, want_lo_q, want_lo_d, shut_q;
    logic pin_q, pin_d;
    logic above, below, hi_ok, lo_ok;

    always_comb
    begin
        // signed compare of nine bit half degree values
        above = $signed(conv_data) > $signed(trip_q[15:READING_LSB]); // see [R21]
        below = $signed(conv_data) < $signed(rel_q[15:READING_LSB]);
        hi_cnt_d = hi_cnt_q;
        lo_cnt_d = lo_cnt_q;
        if (conv_take)
        begin
            // counters saturate at six, the deepest queue
            hi_cnt_d = !above ? 3'h0 :
                (hi_cnt_q == QUEUE_DEPTH_3) ? hi_cnt_q : hi_cnt_q + 3'h1;
            lo_cnt_d = !below ? 3'h0 :
                (lo_cnt_q == QUEUE_DEPTH_3) ? lo_cnt_q : lo_cnt_q + 3'h1;
        end
        hi_ok = conv_take && above &&
            (hi_cnt_d >= queue_need(cfg_q.queue)); // see [R18]
        lo_ok = conv_take && below &&
            (lo_cnt_d >= queue_need(cfg_q.queue));
        act_d = act_q;
        want_lo_d = want_lo_q;
        if (!cfg_q.mode)
        begin
            // comparator keeps its level through shutdown
            want_lo_d = 1'b0;
            if (hi_ok)
                act_d = 1'b1; // see [R23]
            else if (lo_ok)
                act_d = 1'b0; // see [R23]
        end
        else
        begin
            // an event in the read cycle wins over the clear
            if (read_pulse)
                act_d = 1'b0; // see [R24]
            if (cfg_q.shutdown && !shut_q)
                act_d = 1'b0; // see [R26]
            if (!want_lo_q && hi_ok)
            begin
                act_d = 1'b1; // see [R16]
                want_lo_d = 1'b1;
            end
            else if (want_lo_q && lo_ok)
            begin
                act_d = 1'b1;
                want_lo_d = 1'b0;
            end
        end
        pin_d = !(act_d ^ cfg_q.polarity); // see [R17]
    end

    always_ff @(posedge CLK_SYS)
    begin
        if (!RST_N)
        begin
            hi_cnt_q <= '0;
            lo_cnt_q <= '0;
            act_q <= 1'b0;
            want_lo_q <= 1'b0;
            shut_q <= 1'b0;
            pin_q <= 1'b1;
        end
        else
        begin
            hi_cnt_q <= hi_cnt_d;
            lo_cnt_q <= lo_cnt_d;
            act_q <= act_d;
            want_lo_q <= want_lo_d;
            shut_q <= cfg_q.shutdown;
            pin_q <= pin_d;
        end
    end

    assign ALERT_OUTPUT = pin_q;
endmodule
